// File: logic/mcg_pkg.sv
// package: constants for the math coprocessor bus glue
package mcg_pkg;
	// system clock rate
	localparam int unsigned SYS_CLK_HZ      = 20000000;
	// coprocessor clock rate
	localparam int unsigned COPROC_CLK_HZ   = 2000000;
	// half period of the coprocessor clock in system cycles
	localparam int unsigned HALF_DIV        = SYS_CLK_HZ / (2 * COPROC_CLK_HZ);
	localparam int unsigned DIV_W           = 4;
	// address field positions on the I/O address bus
	localparam int unsigned ADDR_W          = 12;
	localparam int unsigned SEL_HI_BIT      = 11;
	localparam int unsigned SEL_LO_BIT      = 10;
	localparam int unsigned KIND_BIT        = 3;
	// reset values
	localparam logic        SEL_N_RST       = 1'b1;
	localparam logic        ACK_N_RST       = 1'b1;
	localparam logic        CLK_RST         = 1'b0;
	localparam logic        KIND_RST        = 1'b0;
	localparam logic        EDGE_RST        = 1'b1;
	// synchroniser depth for pin inputs
	localparam int unsigned SYNC_DEPTH      = 3;
endpackage

// File: logic/mcg_sync.sv
// module: three-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module mcg_sync
	import mcg_pkg::*;
(
	// clock, reset and enable
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	input  wire logic ce_in,
	// pin and filtered level
	input  wire logic pin_in,
	output logic      level_out
);
	logic [SYNC_DEPTH-1:0] stage_q;
	logic [SYNC_DEPTH-1:0] stage_d;
	logic                  level_q;
	logic                  level_d;

	// shift in; accept a change only when the last two stages agree
	always_comb
	begin
		stage_d = stage_q;
		level_d = level_q;
		if (ce_in)
		begin
			stage_d = {stage_q[SYNC_DEPTH-2:0], pin_in};
			if (stage_q[1] == stage_q[2])
				level_d = stage_q[2];
		end
	end

	// registers only
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			stage_q <= '0;
			level_q <= 1'b0;
		end
		else
		begin
			stage_q <= stage_d;
			level_q <= level_d;
		end
	end

	assign level_out = level_q;
endmodule

// File: logic/mcg_top.sv
// module: bus glue between host I/O cycles and the math coprocessor
// pin inputs pass four flops, so every answer lags the pins by a few
// system cycles; the host sees that as wait states, not as a fault
`timescale 1ns/1ps
module mcg_top
	import mcg_pkg::*;
(
	// clock, reset, enable
	input  wire logic              clk_in,
	input  wire logic              arst_n_in,
	input  wire logic              ce_in,
	// host I/O bus
	input  wire logic              io_strobe_n_in,
	input  wire logic [ADDR_W-1:0] addr_in,
	output logic                   bus_ack_n_out,
	// coprocessor side
	input  wire logic              pause_n_in,
	input  wire logic              end_n_in,
	output logic                   coproc_select_n_out,
	output logic                   coproc_cmd_data_out,
	output logic                   two_meg_clock_out,
	// adapter edge input
	output logic                   adapter_edge_input_b_one_out
);
	// reset release
	logic             rst_s1_q;
	logic             rst_n_q;
	// synchronised pin levels, high when active
	logic             strobe_lvl;
	logic             pause_lvl;
	logic             end_lvl;
	// coprocessor clock divider
	logic [DIV_W-1:0] div_q;
	logic [DIV_W-1:0] div_d;
	logic             clk2_q;
	logic             clk2_d;
	// select and transfer kind
	logic             sel_n_q;
	logic             sel_n_d;
	logic             kind_q;
	logic             kind_d;
	// acknowledge and adapter edge output
	logic             ack_n_q;
	logic             ack_n_d;
	logic             edge_q;
	logic             edge_d;

	// address match for the coprocessor window
	function automatic logic is_coproc(input logic [ADDR_W-1:0] a);
		return !a[SEL_HI_BIT] && a[SEL_LO_BIT];
	endfunction

	// reset release through two flops; assertion stays asynchronous
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			rst_s1_q <= 1'b0;
			rst_n_q  <= 1'b0;
		end
		else
		begin
			rst_s1_q <= 1'b1;
			rst_n_q  <= rst_s1_q;
		end
	end

	// host strobe comes from another timing domain
	mcg_sync u_sync_strobe (
		.clk_in    (clk_in),
		.rst_n_in  (rst_n_q),
		.ce_in     (ce_in),
		.pin_in    (~io_strobe_n_in),
		.level_out (strobe_lvl)
	);

	// pause runs on the coprocessor clock, treat as asynchronous
	mcg_sync u_sync_pause (
		.clk_in    (clk_in),
		.rst_n_in  (rst_n_q),
		.ce_in     (ce_in),
		.pin_in    (~pause_n_in),
		.level_out (pause_lvl)
	);

	// completion also comes from the coprocessor clock
	mcg_sync u_sync_end (
		.clk_in    (clk_in),
		.rst_n_in  (rst_n_q),
		.ce_in     (ce_in),
		.pin_in    (~end_n_in),
		.level_out (end_lvl)
	);

	// divider next state; runs free from reset, not tied to accesses
	always_comb
	begin
		div_d  = div_q;
		clk2_d = clk2_q;
		if (ce_in)
		begin
			if (div_q == DIV_W'(HALF_DIV - 1))
			begin
				div_d  = '0;
				clk2_d = ~clk2_q;
			end
			else
			begin
				div_d = div_q + DIV_W'(1);
			end
		end
	end

	// divider registers; a stopped enable stretches the 2 MHz phase
	always_ff @(posedge clk_in or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			div_q  <= '0;
			clk2_q <= CLK_RST;
		end
		else
		begin
			div_q  <= div_d;
			clk2_q <= clk2_d;
		end
	end

	// select and kind; the host holds the address while its strobe is low
	always_comb
	begin
		sel_n_d = sel_n_q;
		kind_d  = kind_q;
		if (ce_in)
		begin
			sel_n_d = !(strobe_lvl && is_coproc(addr_in));
			// data or command by bit three
			kind_d  = addr_in[KIND_BIT];
		end
	end

	// decode registers; address is sampled after the strobe settles
	always_ff @(posedge clk_in or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			sel_n_q <= SEL_N_RST;
			kind_q  <= KIND_RST;
		end
		else
		begin
			sel_n_q <= sel_n_d;
			kind_q  <= kind_d;
		end
	end

	// ack next state; a paused coprocessor keeps the host in wait states
	always_comb
	begin
		ack_n_d = ack_n_q;
		if (ce_in)
		begin
			if (!strobe_lvl)
				ack_n_d = 1'b1;
			else if (!sel_n_q && !pause_lvl)
				ack_n_d = 1'b0;
		end
	end

	// ack register; released one cycle after the synced strobe drops
	always_ff @(posedge clk_in or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			ack_n_q <= ACK_N_RST;
		end
		else
		begin
			ack_n_q <= ack_n_d;
		end
	end

	// edge output copies the synced completion; the adapter finds the edge
	always_comb
	begin
		edge_d = edge_q;
		if (ce_in)
		begin
			edge_d = ~end_lvl;
		end
	end

	// edge register; resets to the idle level so no false edge follows
	always_ff @(posedge clk_in or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			edge_q <= EDGE_RST;
		end
		else
		begin
			edge_q <= edge_d;
		end
	end

	// outputs straight from flops
	assign bus_ack_n_out                = ack_n_q;
	assign coproc_select_n_out          = sel_n_q;
	assign coproc_cmd_data_out          = kind_q;
	assign two_meg_clock_out            = clk2_q;
	assign adapter_edge_input_b_one_out = edge_q;
endmodule

// File: testbench/mcg_chk_assertions.sv
// checker: port assertions for the bus glue
`timescale 1ns/1ps
module mcg_chk
	import mcg_pkg::*;
(
	// watched top-level ports
	input wire logic              clk_in,
	input wire logic              arst_n_in,
	input wire logic              ce_in,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic              bus_ack_n_out,
	input wire logic              pause_n_in,
	input wire logic              end_n_in,
	input wire logic              coproc_select_n_out,
	input wire logic              coproc_cmd_data_out,
	input wire logic              two_meg_clock_out,
	input wire logic              adapter_edge_input_b_one_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);
	property p_sel;
		!coproc_select_n_out |->
			!addr_in[SEL_HI_BIT] && addr_in[SEL_LO_BIT];
	endproperty
	a_sel: assert property (p_sel) else $error("bad select");
	property p_kind;
		!coproc_select_n_out |->
			coproc_cmd_data_out == addr_in[KIND_BIT];
	endproperty
	a_kind: assert property (p_kind) else $error("bad kind");
	// a low enable freezes the divider, so the phase check stands down
	property p_clk;
		disable iff (!arst_n_in || !ce_in)
		$rose(two_meg_clock_out) |=>
			two_meg_clock_out[*4] ##1 !two_meg_clock_out;
	endproperty
	a_clk: assert property (p_clk) else $error("bad clock");
	property p_hold; $fell(bus_ack_n_out) |-> $past(pause_n_in, 3); endproperty
	a_hold: assert property (p_hold) else $error("ack in pause");
	property p_edge; $stable(end_n_in)[*8] ##1 $stable(end_n_in) |->
		adapter_edge_input_b_one_out == end_n_in; endproperty
	a_edge: assert property (p_edge) else $error("bad edge");
	property p_ack; pause_n_in[*6] ##0 $fell(coproc_select_n_out) |=>
		!bus_ack_n_out; endproperty
	a_ack: assert property (p_ack) else $error("late ack");
	// main scenarios: plain ack, paused select, completion
	cover property (!bus_ack_n_out);
	cover property (!pause_n_in && !coproc_select_n_out);
	cover property ($fell(adapter_edge_input_b_one_out));
endmodule

// File: testbench/mcg_coproc.sv
// partner: behavioural coprocessor with a busy period
`timescale 1ns/1ps
module mcg_coproc (
	input  wire logic clk_in,
	input  wire logic select_n_in,
	input  wire logic cmd_in,
	output logic      pause_n_out,
	output logic      end_n_out
);
	int   busy = 0;
	logic done = 1'b0;
	// a command starts a 20 cycle job; pause whole job, so sync lag is safe
	always @(posedge clk_in)
		if (busy > 0)
			busy <= busy - 1;
		else if (!select_n_in && cmd_in)
		begin
			busy <= 20;
			done <= 1'b1;
		end
	assign pause_n_out = (busy == 0);
	// completion idles high until a first job has finished
	assign end_n_out   = !(done && busy == 0);
endmodule

// File: testbench/mcg_top_test.sv
// testbench: host accesses against the glue and coprocessor model
`timescale 1ns/1ps
module mcg_top_test;
	import mcg_pkg::*;
	logic              clk_in = 0, arst_n_in = 0, stb_n = 1, ce = 1;
	logic [ADDR_W-1:0] addr = '0;
	logic              ack_n, sel_n, cmd, clk2, edge_o, pause_n, end_n;
	int                n_fail = 0, checked = 0, lat, n;
	initial forever #25 clk_in = ~clk_in;
	mcg_top u_mcg_top (.clk_in(clk_in), .arst_n_in(arst_n_in), .ce_in(ce),
		.io_strobe_n_in(stb_n), .addr_in(addr), .bus_ack_n_out(ack_n),
		.pause_n_in(pause_n), .end_n_in(end_n), .coproc_select_n_out(sel_n),
		.coproc_cmd_data_out(cmd), .two_meg_clock_out(clk2),
		.adapter_edge_input_b_one_out(edge_o));
	mcg_coproc u_mcg_coproc (.clk_in(clk_in), .select_n_in(sel_n),
		.cmd_in(cmd), .pause_n_out(pause_n), .end_n_out(end_n));
	// compare one value against the bench expectation
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// system cycles until the 2 MHz clock next rises, bounded
	task automatic wait_rise(output int cnt);
		logic prev;
		cnt = 0;
		prev = clk2;
		while (!(prev === 1'b0 && clk2 === 1'b1) && cnt < 40)
		begin
			prev = clk2;
			@(posedge clk_in);
			#1 cnt++;
		end
	endtask
	// one host access; acked ones must land within lo..hi cycles
	task automatic acc(input logic [ADDR_W-1:0] a, input int lo, input int hi);
		addr = a;
		stb_n = 0;
		lat = 0;
		while (ack_n !== 1'b0 && lat < 60)
		begin
			@(posedge clk_in);
			#1 lat++;
		end
		if (a[11:10] != 2'b01)
			chk(16'({ack_n, sel_n, 8'(lat)}), 16'h33c);
		else if (lat >= 60)
		begin
			chk(16'(lat), 16'(hi));
			report_and_stop();
		end
		else
			chk({cmd, 7'h0, 8'(lat >= lo && lat <= hi)}, {a[3], 15'h1});
		stb_n = 1;
		repeat (12) @(posedge clk_in);
		#1;
	endtask
	initial
	begin
		void'($urandom(32'h4426de01));
		repeat (4) @(posedge clk_in);
		#1 arst_n_in = 1;
		repeat (8) @(posedge clk_in);
		#1;
		// idle levels after reset, no false completion edge
		chk(16'({ack_n, sel_n, edge_o}), 16'h7);
		// all four decode combinations, random low bits, data kind
		for (int i = 0; i < 4; i++)
			acc({2'(i), 10'($urandom) & 10'h3f7}, 5, 7);
		acc(12'h408, 5, 7);
		chk(edge_o, 1'b1);
		acc(12'h400, 8, 40);
		chk(edge_o, 1'b0);
		// enable low freezes all state, a strobe in the window too
		ce = 1'b0;
		n = 32'({ack_n, sel_n, cmd, clk2, edge_o});
		addr = 12'h400;
		stb_n = 0;
		repeat (30) @(posedge clk_in);
		#1 chk(16'({ack_n, sel_n, cmd, clk2, edge_o}), 16'(n));
		stb_n = 1;
		@(posedge clk_in);
		#1 ce = 1'b1;
		repeat (8) @(posedge clk_in);
		// no stale select after the freeze
		#1 chk(16'({ack_n, sel_n}), 16'h3);
		// one coprocessor clock period in system cycles
		wait_rise(n);
		if (n >= 40)
			chk(16'(n), 16'h0);
		wait_rise(n);
		chk(16'(n), 16'(SYS_CLK_HZ / COPROC_CLK_HZ));
		report_and_stop();
	end
endmodule
bind mcg_top mcg_chk u_mcg_chk (
	.clk_in                       (clk_in),
	.arst_n_in                    (arst_n_in),
	.ce_in                        (ce_in),
	.addr_in                      (addr_in),
	.bus_ack_n_out                (bus_ack_n_out),
	.pause_n_in                   (pause_n_in),
	.end_n_in                     (end_n_in),
	.coproc_select_n_out          (coproc_select_n_out),
	.coproc_cmd_data_out          (coproc_cmd_data_out),
	.two_meg_clock_out            (two_meg_clock_out),
	.adapter_edge_input_b_one_out (adapter_edge_input_b_one_out)
);
